// File: include/rcc_params.svh
// constants for the relay channel control register bank
`ifndef RCC_PARAMS_SVH
`define RCC_PARAMS_SVH
`define RCC_NUM_REGS 10
`define RCC_NUM_CHANS 80
`define RCC_GROUP_BITS 8
`define RCC_MOD_ADDR_MIN 4'h1
`define RCC_MOD_ADDR_MAX 4'hC
`define RCC_MOD_SHIFT 10
`define RCC_REG0_OFS 10'h001
`define RCC_REG1_OFS 10'h003
`define RCC_REG2_OFS 10'h005
`define RCC_REG_RESET 8'h00
`define RCC_USED_MASK 80'hFFFF_FFFF_FFFF_FFFF_FFFF
`define RCC_WB_REQ_ADR 4'h4
`define RCC_WB_REQ_GO 4'h8
`define RCC_WB_GO_WE_BIT 0
`define RCC_WB_GO_DAT_LSB 8
`define RCC_WB_STATUS 4'hC
`define RCC_WB_OFFSET 4'h0
`endif

// File: include/rcc_pkg.sv
// types shared by the relay channel control ends
package rcc_pkg;
    typedef logic [23:0] rcc_addr_t;
    typedef logic [7:0] rcc_byte_t;
    typedef logic [3:0] rcc_modaddr_t;
    typedef enum logic [2:0] {
        RCC_IDLE = 3'b001,
        RCC_BUSY = 3'b010,
        RCC_DONE = 3'b100
    } rcc_state_t;
endpackage : rcc_pkg

// File: include/rcc_a24_if.sv
// A24 byte access link between the carrier master and the relay plug-in
`timescale 1ns/10ps
interface rcc_a24_if;
    logic [23:0] addr;
    logic [7:0] wdata;
    logic we;
    logic req;
    logic [7:0] rdata;
    logic ack;
    modport master (output addr, output wdata, output we, output req,
        input rdata, input ack);
    modport plugin (input addr, input wdata, input we, input req,
        output rdata, output ack);
endinterface : rcc_a24_if

// File: rtl/rcc_decode.sv
// address decoder: finds the control register selected by an A24 address
`timescale 1ns/10ps
`include "rcc_params.svh"
module rcc_decode
    import rcc_pkg::*;
(
    input wire rcc_addr_t addr_i,
    input wire rcc_addr_t a24_offset_i,
    input wire rcc_modaddr_t mod_addr_i,
    output logic hit_o,
    output logic [3:0] index_o
);
    rcc_addr_t base;
    rcc_addr_t rel;

    // base = offset + 1024 x module address; odd bytes only
    always_comb begin
        base = a24_offset_i + {10'h000, mod_addr_i, 10'h000};
        rel = addr_i - base;
        index_o = rel[4:1];
        hit_o = 1'b0;
        if ((mod_addr_i < `RCC_MOD_ADDR_MIN) || (mod_addr_i > `RCC_MOD_ADDR_MAX)) begin
            hit_o = 1'b0;
        end else if ((rel[23:5] == 19'h00000) && rel[0]
                && (rel[4:1] < 4'(`RCC_NUM_REGS))) begin
            hit_o = 1'b1;
        end
    end
endmodule : rcc_decode

// File: rtl/rcc_plugin.sv
// relay plug-in end: bank of byte-wide relay control registers
`timescale 1ns/10ps
`include "rcc_params.svh"
module rcc_plugin
    import rcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    rcc_a24_if.plugin bus,
    input wire rcc_addr_t a24_offset_i,
    input wire rcc_modaddr_t mod_addr_i,
    output logic [`RCC_NUM_CHANS-1:0] relay_close_o
);
    rcc_byte_t ctrl_r [`RCC_NUM_REGS];
    rcc_byte_t ctrl_nxt [`RCC_NUM_REGS];
    rcc_byte_t rdata_r;
    rcc_byte_t rdata_nxt;
    logic ack_r;
    logic ack_nxt;
    logic hit;
    logic [3:0] idx;
    logic [`RCC_NUM_CHANS-1:0] used;

    assign used = `RCC_USED_MASK;

    rcc_decode u_dec (
        .addr_i(bus.addr),
        .a24_offset_i(a24_offset_i),
        .mod_addr_i(mod_addr_i),
        .hit_o(hit),
        .index_o(idx)
    );

    // one-cycle ack per request; unmapped reads return zero
    always_comb begin
        for (int k = 0; k < `RCC_NUM_REGS; k++) begin
            ctrl_nxt[k] = ctrl_r[k];
        end
        rdata_nxt = rdata_r;
        ack_nxt = 1'b0;
        if (bus.req && !ack_r) begin
            ack_nxt = 1'b1;
            rdata_nxt = 8'h00;
            if (hit && bus.we) begin
                ctrl_nxt[idx] = bus.wdata; // whole byte at once
            end else if (hit) begin
                // inverse of stored value, masked by fitted relays
                rdata_nxt = ~ctrl_r[idx] & used[idx*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int k = 0; k < `RCC_NUM_REGS; k++) begin
                ctrl_r[k] <= `RCC_REG_RESET;
            end
            rdata_r <= 8'h00;
            ack_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end

    // bit j of register k closes channel 8k+j when set
    always_comb begin
        for (int k = 0; k < `RCC_NUM_REGS; k++) begin
            relay_close_o[k*8 +: 8] = ctrl_r[k] & used[k*8 +: 8];
        end
    end

    assign bus.rdata = rdata_r;
    assign bus.ack = ack_r;
endmodule : rcc_plugin

// File: rtl/rcc_carrier.sv
// carrier end: Wishbone slave that issues A24 byte accesses to the plug-in
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "rcc_params.svh"
module rcc_carrier
    import rcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output rcc_addr_t a24_offset_o,
    rcc_a24_if.master bus
);
    rcc_addr_t offset_r, offset_nxt;
    rcc_addr_t adr_r, adr_nxt;
    rcc_byte_t dat_r, dat_nxt;
    rcc_byte_t rd_r, rd_nxt;
    logic we_r, we_nxt;
    rcc_state_t st_r, st_nxt;
    logic [31:0] wbd_r, wbd_nxt;
    logic ack_r, ack_nxt;
    logic acc;

    assign acc = wb_cyc_i && wb_stb_i && !ack_r;

    // register decode and access sequencer; offset written before use
    always_comb begin
        offset_nxt = offset_r;
        adr_nxt = adr_r;
        dat_nxt = dat_r;
        rd_nxt = rd_r;
        we_nxt = we_r;
        st_nxt = st_r;
        wbd_nxt = wbd_r;
        ack_nxt = 1'b0;
        case (st_r)
            RCC_IDLE: begin
                if (acc) begin
                    ack_nxt = 1'b1;
                    wbd_nxt = 32'h0000_0000;
                    if (wb_adr_i == `RCC_WB_OFFSET && wb_sel_i == 4'hF) begin
                        if (wb_we_i) offset_nxt = wb_dat_i[23:0];
                        wbd_nxt = {8'h00, offset_r};
                    end else if (wb_adr_i == `RCC_WB_REQ_ADR) begin
                        if (wb_we_i) adr_nxt = wb_dat_i[23:0];
                        wbd_nxt = {8'h00, adr_r};
                    end else if (wb_adr_i == `RCC_WB_REQ_GO) begin
                        // data byte rides with the go bit: only four word slots exist
                        if (wb_we_i) begin
                            dat_nxt = wb_dat_i[`RCC_WB_GO_DAT_LSB +: 8];
                            we_nxt = wb_dat_i[`RCC_WB_GO_WE_BIT];
                            st_nxt = RCC_BUSY;
                        end
                        wbd_nxt = {24'h000000, dat_r};
                    end else if (wb_adr_i == `RCC_WB_STATUS) begin
                        wbd_nxt = {23'h000000, st_r == RCC_BUSY, rd_r};
                    end
                end
            end
            RCC_BUSY: begin
                if (bus.ack) begin
                    rd_nxt = bus.rdata;
                    st_nxt = RCC_DONE;
                end
            end
            RCC_DONE: begin
                st_nxt = RCC_IDLE; // request drops one cycle before next
            end
            default: st_nxt = RCC_IDLE;
        endcase
        // answer bus even while busy: status only
        if (st_r != RCC_IDLE && acc) begin
            ack_nxt = 1'b1;
            wbd_nxt = {23'h000000, 1'b1, rd_r};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            offset_r <= 24'h000000;
            adr_r <= 24'h000000;
            dat_r <= 8'h00;
            rd_r <= 8'h00;
            we_r <= 1'b0;
            st_r <= RCC_IDLE;
            wbd_r <= 32'h0000_0000;
            ack_r <= 1'b0;
        end else begin
            offset_r <= offset_nxt;
            adr_r <= adr_nxt;
            dat_r <= dat_nxt;
            rd_r <= rd_nxt;
            we_r <= we_nxt;
            st_r <= st_nxt;
            wbd_r <= wbd_nxt;
            ack_r <= ack_nxt;
        end
    end

    assign bus.req = (st_r == RCC_BUSY);
    assign bus.addr = adr_r;
    assign bus.wdata = dat_r;
    assign bus.we = we_r;
    assign wb_dat_o = wbd_r;
    assign wb_ack_o = ack_r;
    assign a24_offset_o = offset_r;
endmodule : rcc_carrier

// File: bench/rcc_link_chk.sv
// checker on the A24 link between carrier and plug-in
`timescale 1ns/10ps
module rcc_link_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [23:0] addr,
    input wire logic [7:0] wdata,
    input wire logic we,
    input wire logic req,
    input wire logic [7:0] rdata,
    input wire logic ack,
    input wire logic [23:0] a24_offset_i,
    input wire logic [3:0] mod_addr_i,
    input wire logic [79:0] relay_close_o
);
    logic [23:0] rel;
    logic hit, go;
    logic [3:0] idx_r;
    logic [7:0] grp;
    logic rst_d;
    // decode rebuilt apart from the design, odd offsets only
    always_comb begin
        rel = addr - a24_offset_i - {10'h000, mod_addr_i, 10'h000};
        hit = mod_addr_i inside {[4'h1:4'hC]} && rel[0] && rel < 24'h000014;
        go = req && !ack;
        grp = 8'(relay_close_o >> {idx_r, 3'h0});
    end
    // group index one edge back, since the write lands a cycle later
    always_ff @(posedge clk_i) idx_r <= rel[4:1];
    // relays drop the edge after a short reset, so keep checks off one more cycle
    always_ff @(posedge clk_i) rst_d <= rst_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || rst_d);
    property p_ack_pulse; ack |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_answer; go |=> ack; endproperty
    a_answer: assert property (p_answer) else $error("no ack");
    property p_req_drop; ack |=> !req; endproperty
    a_req_drop: assert property (p_req_drop) else $error("req held");
    // reset check must run while reset is high
    property p_reset_open; disable iff (1'h0) rst_i |=> relay_close_o == 80'h0; endproperty
    a_reset_open: assert property (p_reset_open) else $error("relay closed");
    property p_write_hit; go && we && hit |=> grp == $past(wdata); endproperty
    a_write_hit: assert property (p_write_hit)
        else $error("bad group");
    property p_read_inv; go && !we && hit |=> rdata == ~grp; endproperty
    a_read_inv: assert property (p_read_inv) else $error("bad readback");
    property p_miss_keep; go && !hit |=> $stable(relay_close_o); endproperty
    a_miss_keep: assert property (p_miss_keep)
        else $error("miss wrote");
    property p_miss_zero; go && !we && !hit |=> rdata == 8'h00; endproperty
    a_miss_zero: assert property (p_miss_zero) else $error("miss data");
    property p_idle_keep; !go |=> $stable(relay_close_o); endproperty
    a_idle_keep: assert property (p_idle_keep) else $error("relay moved");
endmodule : rcc_link_chk

// File: bench/testbench.sv
// bench: Wishbone into the carrier, relays watched at the plug-in
`timescale 1ns/10ps
module testbench
    import rcc_pkg::*;
;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0, ack;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0, q, rsp;
    rcc_addr_t ofs;
    rcc_modaddr_t mod = 4'h7;
    logic [79:0] relays, exp_r = 80'h0;
    logic [7:0] rd;
    int err_total = 0, checks_done = 0;
    rcc_a24_if link ();
    // 250 MHz clock
    always #2 clk_i = ~clk_i;
    rcc_carrier rcc_carrier_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(q),
        .wb_ack_o(ack), .a24_offset_o(ofs), .bus(link));
    rcc_plugin rcc_plugin_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(link),
        .a24_offset_i(ofs), .mod_addr_i(mod), .relay_close_o(relays));
    rcc_link_chk rcc_link_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .addr(link.addr),
        .wdata(link.wdata), .we(link.we), .req(link.req), .rdata(link.rdata), .ack(link.ack),
        .a24_offset_i(ofs), .mod_addr_i(mod), .relay_close_o(relays));
    // verdict and end of run
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    // compare one result, counted either way
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle; held until ack is sampled, then released
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 50);
        rsp = q;
        {cyc, stb} <= 2'h0;
        @(posedge clk_i);
        if (n >= 50) chk(80'h0, 80'h1);
    endtask : wb
    // one A24 byte access; busy is polled, never assumed
    task automatic acc(input rcc_addr_t a, input logic [7:0] d, input logic w);
        int n;
        n = 0;
        wb(1'h1, 4'h4, {8'h00, a});
        wb(1'h1, 4'h8, {16'h0000, d, 7'h00, w});
        do begin
            wb(1'h0, 4'hC, 32'h0);
            n++;
        end while (rsp[8] !== 1'h0 && n < 20);
        if (rsp[8] !== 1'h0) chk(80'h0, 80'h1);
        rd = rsp[7:0];
    endtask : acc
    // expected address of register k under the current module address
    function automatic rcc_addr_t ra(input int k);
        return 24'h204000 + {10'h000, mod, 10'h000} + 24'(2 * k + 1);
    endfunction : ra
    // watchdog: the run needs only a few hundred cycles
    initial begin
        #(4 * 20000);
        err_total++;
        final_report();
    end
    // main sequence
    initial begin
        rcc_addr_t miss [3];
        rcc_modaddr_t mods [4];
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk(relays, 80'h0);
        wb(1'h1, 4'h0, 32'h00204000);
        chk(80'(ofs), 80'h204000);
        for (int k = 0; k < 10; k++) begin
            acc(ra(k), 8'(8'h85 + k), 1'h1);
            exp_r[8*k +: 8] = 8'(8'h85 + k);
            chk(relays, exp_r);
        end
        for (int k = 0; k < 10; k += 3) begin
            acc(ra(k), 8'h00, 1'h0);
            chk(80'(rd ^ exp_r[8*k +: 8]), 80'hFF);
        end
        // whole group 8 to 15 closed by one write, both ends included
        acc(ra(1), 8'hFF, 1'h1);
        exp_r[15:8] = 8'hFF;
        chk(relays, exp_r);
        // even address, next module's window, index past the last register
        miss = '{ra(0) - 24'h1, ra(0) + 24'h400, ra(10)};
        foreach (miss[i]) begin
            acc(miss[i], 8'hFF, 1'h1);
            chk(relays, exp_r);
            acc(miss[i], 8'hFF, 1'h0);
            chk(80'(rd), 80'h0);
        end
        // module address bounds: only 1 and 12 may hit
        mods = '{4'h0, 4'h1, 4'hC, 4'hD};
        foreach (mods[i]) begin
            mod <= mods[i];
            @(posedge clk_i);
            acc(ra(9), 8'(i + 1), 1'h1);
            if (mods[i] inside {4'h1, 4'hC}) exp_r[79:72] = 8'(i + 1);
            chk(relays, exp_r);
        end
        // reset in mid-run opens everything again
        rst_i <= 1'h1;
        @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk(relays, 80'h0);
        final_report();
    end
endmodule : testbench
